// *** design/tls_pkg.sv ***
// Constants and types shared by the transfer load sequencer.
package tls_pkg;
	localparam int          CLK_HZ         = 125_000_000;
	localparam int          TENTH_MS       = 100;
	localparam int          TENTH_CYCLES   = CLK_HZ / 1000 * TENTH_MS;
	localparam logic [3:0]  TENTHS_PER_SEC = 4'hA;
	localparam int          NUM_LOADS      = 9;
	localparam logic [15:0] MAX_LOAD_SEC   = 16'h0E10;
	localparam logic [15:0] SEC_PER_MIN    = 16'h003C;

	// ===========================================================
	// Register byte offsets and load table page codes
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_XFER_DLY = 8'h08;
	localparam logic [7:0] REG_SYNC     = 8'h0C;
	localparam logic [7:0] REG_DEBOUNCE = 8'h10;
	localparam logic [7:0] REG_SRC_CFG  = 8'h14;
	localparam logic [7:0] REG_ROLE_DLY = 8'h18;
	localparam logic [1:0] LOAD1_PAGE   = 2'h1;
	localparam logic [1:0] LOAD2_PAGE   = 2'h2;

	// ===========================================================
	// Field positions
	localparam int F_EN1   = 0;
	localparam int F_EN2   = 1;
	localparam int F_PREF  = 2;
	localparam int F_MODEL = 3;
	localparam int F_ROT   = 5;
	localparam int F_IPM   = 7;
	localparam int F_MODE  = 8;
	localparam int F_CNT1  = 10;
	localparam int F_CNT2  = 14;
	localparam int F_WIN   = 0;
	localparam int F_VLIM  = 4;
	localparam int F_FLIM  = 7;
	localparam int F_ALIM  = 9;
	localparam int F_FAIL  = 13;
	localparam int F_DISC  = 0;
	localparam int F_RECON = 12;

	// ===========================================================
	// Reset values and limits
	localparam logic [17:0] CTRL_RST = 18'h04400;
	localparam logic [24:0] SYNC_RST = 25'h003D4D5;
	localparam logic [6:0]  DEB_RST  = 7'h05;
	localparam logic [11:0] WIN_MIN  = 12'h005;
	localparam logic [11:0] WIN_MAX  = 12'h00F;
	localparam logic [11:0] VLIM_MAX = 12'h005;
	localparam logic [11:0] FLIM_MAX = 12'h003;
	localparam logic [11:0] ALIM_MAX = 12'h00A;
	localparam logic [11:0] FAIL_MAX = 12'hE10;
	localparam logic [11:0] DEB_MIN  = 12'h001;
	localparam logic [11:0] DEB_MAX  = 12'h063;
	localparam logic [11:0] CNT_MIN  = 12'h001;
	localparam logic [11:0] CNT_MAX  = 12'h009;

	// ===========================================================
	// Mode codes
	localparam logic [1:0] MODEL_STD    = 2'h0;
	localparam logic [1:0] MODEL_PGM    = 2'h1;
	localparam logic [1:0] MODEL_CLOSED = 2'h2;
	localparam logic [1:0] ROT_OFF      = 2'h0;
	localparam logic [1:0] ROT_FWD      = 2'h1;
	localparam logic [1:0] ROT_REV      = 2'h2;
	localparam logic [1:0] MODE_UG      = 2'h0;
	localparam logic [1:0] MODE_UU      = 2'h1;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_PRE,
		ST_SYNC,
		ST_XFER,
		ST_POST
	} tls_state_type;
endpackage

// *** design/tls_sequencer.sv ***
// Load shed and restore sequencer with sync gating and Wishbone registers.
`timescale 1ns/1ns

module tls_sequencer
#(
	parameter int TENTH_CYCLES = tls_pkg::TENTH_CYCLES
)
(
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire logic [7:0]                   adr_i,
	input  wire logic [31:0]                  dat_i,
	output logic      [31:0]                  dat_o,
	input  wire logic                         we_i,
	input  wire logic [3:0]                   sel_i,
	input  wire logic                         cyc_i,
	input  wire logic                         stb_i,
	output logic                              ack_o,
	input  wire logic [1:0]                   src_live_i,
	input  wire logic [1:0]                   pos_i,
	input  wire logic                         xfer_req_i,
	input  wire logic                         conn_low_i,
	input  wire logic [1:0]                   rot_rev_i,
	input  wire logic                         approaching_i,
	input  wire logic [7:0]                   angle_diff_i,
	input  wire logic [7:0]                   volt_diff_i,
	input  wire logic [7:0]                   freq_diff_i,
	output logic      [1:0]                   xfer_cmd_o,
	output logic      [tls_pkg::NUM_LOADS-1:0] load_open_o,
	output logic                              sync_fail_o,
	output logic                              seq_busy_o
);
	import tls_pkg::*;

	typedef struct packed
	{
		logic                  ack;
		logic [31:0]           rdat;
		logic [17:0]           ctrl;
		logic [31:0]           xdly;
		logic [24:0]           sync;
		logic [6:0]            deb;
		logic [31:0]           srcc;
		logic [31:0]           rdly;
		logic [17:0][23:0]     ld;
		tls_state_type         st;
		logic                  tgt;
		logic [15:0]           el;
		logic [23:0]           div;
		logic [3:0]            sdiv;
		logic                  tenth;
		logic                  sec;
		logic [1:0][6:0]       bad;
		logic [1:0]            avail;
		logic [NUM_LOADS-1:0]  lo;
		logic [1:0]            cmd;
		logic                  fail;
		logic                  busy;
	} tls_regs_type;

	tls_regs_type q;
	tls_regs_type nxt;

	// ===========================================================
	// Helpers
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic [11:0] lim(input logic [11:0] v,
		input logic [11:0] lo, input logic [11:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// Minutes in bits 11:6, seconds in bits 5:0, capped at one hour.
	function automatic logic [15:0] mmss(input logic [11:0] f);
		logic [15:0] t;
		t = 16'({10'h0, f[11:6]} * SEC_PER_MIN) + {10'h0, f[5:0]};
		return (t > MAX_LOAD_SEC) ? MAX_LOAD_SEC : t;
	endfunction

	function automatic logic [15:0] max_of(input logic [15:0] base,
		input logic [NUM_LOADS-1:0][15:0] d,
		input logic [NUM_LOADS-1:0] m);
		logic [15:0] r;
		r = base;
		for (int i = 0; i < NUM_LOADS; i++)
		begin
			if (m[i] && d[i] > r)
				r = d[i];
		end
		return r;
	endfunction

	// ===========================================================
	// Per-load decode for the source being transferred to
	logic                        pref;
	logic                        both;
	logic                        want;
	logic [1:0]                  model;
	logic [1:0]                  rot_eff;
	logic                        rot_ok;
	logic                        ipm_on;
	logic                        diff_bad;
	logic                        win_ok;
	logic                        hold;
	logic [3:0]                  cnt_t;
	logic                        en_t;
	logic [15:0]                 tdly;
	logic [15:0]                 t_max;
	logic [NUM_LOADS-1:0]        part;
	logic [NUM_LOADS-1:0]        pre_part;
	logic [NUM_LOADS-1:0]        pre_open;
	logic [NUM_LOADS-1:0]        post_open;
	logic [NUM_LOADS-1:0][15:0]  disc_s;
	logic [NUM_LOADS-1:0][15:0]  rec_s;
	logic [7:0]                  idx;
	logic [31:0]                 wv;
	logic [11:0]                 lc1;
	logic [11:0]                 lc2;
	logic [11:0]                 lw;
	logic [11:0]                 lv;
	logic [11:0]                 lf;
	logic [11:0]                 la;
	logic [11:0]                 ldb;

	assign pref  = q.ctrl[F_PREF];
	assign both  = &q.avail;
	assign model = q.ctrl[F_MODEL +: 2];
	// Load tables stay with the physical side, not the role.
	assign cnt_t = q.tgt ? q.ctrl[F_CNT2 +: 4] : q.ctrl[F_CNT1 +: 4];
	assign en_t  = q.tgt ? q.ctrl[F_EN2] : q.ctrl[F_EN1];
	// Low half is preferred-to-standby, high half standby-to-preferred.
	assign tdly  = (q.tgt == pref) ? q.xdly[31:16] : q.xdly[15:0];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_LOADS; gi++)
		begin : g_load
			assign disc_s[gi]    = mmss(q.ld[q.tgt ? gi + NUM_LOADS : gi][F_DISC +: 12]);
			assign rec_s[gi]     = mmss(q.ld[q.tgt ? gi + NUM_LOADS : gi][F_RECON +: 12]);
			assign part[gi]      = en_t && (4'(gi) < cnt_t);
			assign pre_part[gi]  = part[gi] && both;
			assign pre_open[gi]  = pre_part[gi] &&
				({1'b0, q.el} + {1'b0, disc_s[gi]} >= {1'b0, t_max});
			assign post_open[gi] = q.lo[gi] && (q.el < rec_s[gi]);
		end
	endgenerate

	assign t_max = max_of(tdly, disc_s, pre_part);

	// Seek the preferred source; a test or peak shave request goes to standby while both are available.
	assign want = (xfer_req_i && both) ? ~pref
		: (q.avail[pref] ? pref : ~pref);

	assign rot_eff = (model == MODEL_CLOSED && q.ctrl[F_ROT +: 2] == ROT_OFF)
		? ROT_FWD : q.ctrl[F_ROT +: 2];
	assign rot_ok  = (rot_eff == ROT_OFF) ||
		(rot_rev_i[q.tgt] == (rot_eff == ROT_REV));
	assign ipm_on  = (model == MODEL_CLOSED) ||
		(model == MODEL_STD && q.ctrl[F_IPM]);
	assign diff_bad = (volt_diff_i > {5'h0, q.sync[F_VLIM +: 3]}) ||
		(freq_diff_i > {6'h0, q.sync[F_FLIM +: 2]}) ||
		(angle_diff_i > {4'h0, q.sync[F_ALIM +: 4]});
	assign win_ok  = approaching_i &&
		(angle_diff_i <= {4'h0, q.sync[F_WIN +: 4]});
	assign hold    = !rot_ok || (ipm_on && both && !conn_low_i &&
		((model == MODEL_CLOSED) ? diff_bad
		: (q.ctrl[F_MODE +: 2] != MODE_UU && !win_ok)));

	assign idx = {4'h0, adr_i[5:2]} + ((adr_i[7:6] == LOAD2_PAGE) ? 8'h09 : 8'h00);

	// ===========================================================
	// Next state
	always_comb
	begin
		nxt = q;
		wv = 32'h0;
		lc1 = 12'h000;
		lc2 = 12'h000;
		lw = 12'h000;
		lv = 12'h000;
		lf = 12'h000;
		la = 12'h000;
		ldb = 12'h000;
		nxt.ack = cyc_i & stb_i & ~q.ack;
		nxt.tenth = 1'b0;
		nxt.sec = 1'b0;
		if (q.div == 24'(TENTH_CYCLES - 1))
		begin
			nxt.div = '0;
			nxt.tenth = 1'b1;
		end
		else
			nxt.div = q.div + 24'h000001;
		if (q.tenth)
		begin
			if (q.sdiv == TENTHS_PER_SEC - 4'h1)
			begin
				nxt.sdiv = '0;
				nxt.sec = 1'b1;
			end
			else
				nxt.sdiv = q.sdiv + 4'h1;
		end
		for (int k = 0; k < 2; k++)
		begin
			if (src_live_i[k])
			begin
				nxt.bad[k] = '0;
				nxt.avail[k] = 1'b1;
			end
			else if (q.tenth)
			begin
				if (q.bad[k] >= q.deb)
					nxt.avail[k] = 1'b0;
				else
					nxt.bad[k] = q.bad[k] + 7'h01;
			end
		end

		// Register access is committed on the edge that raises ack.
		if (cyc_i && stb_i && !q.ack)
		begin
			case (adr_i)
				REG_CTRL:     nxt.rdat = {14'h0, q.ctrl};
				REG_STATUS:   nxt.rdat = {15'h0, q.st, q.lo, q.busy,
					q.tgt, q.avail, q.fail};
				REG_XFER_DLY: nxt.rdat = q.xdly;
				REG_SYNC:     nxt.rdat = {7'h0, q.sync};
				REG_DEBOUNCE: nxt.rdat = {25'h0, q.deb};
				REG_SRC_CFG:  nxt.rdat = q.srcc;
				REG_ROLE_DLY: nxt.rdat = q.rdly;
				default:      nxt.rdat = (adr_i[7:6] != 2'h0 &&
					adr_i[7:6] != 2'h3 && adr_i[5:2] < 4'h9)
					? {8'h0, q.ld[idx[4:0]]} : 32'h0;
			endcase
			if (we_i)
			begin
				case (adr_i)
					REG_CTRL:
					begin
						wv = merge({14'h0, q.ctrl}, dat_i, sel_i);
						lc2 = lim({8'h0, wv[F_CNT2 +: 4]}, CNT_MIN, CNT_MAX);
						lc1 = lim({8'h0, wv[F_CNT1 +: 4]}, CNT_MIN, CNT_MAX);
						nxt.ctrl = {lc2[3:0], lc1[3:0], wv[9:0]};
					end
					REG_STATUS:
					begin
						if (sel_i[0] && dat_i[0])
							nxt.fail = 1'b0;
					end
					REG_XFER_DLY: nxt.xdly = merge(q.xdly, dat_i, sel_i);
					REG_SYNC:
					begin
						wv = merge({7'h0, q.sync}, dat_i, sel_i);
						la = lim({8'h0, wv[F_ALIM +: 4]}, 12'h0, ALIM_MAX);
						lf = lim({10'h0, wv[F_FLIM +: 2]}, 12'h0, FLIM_MAX);
						lv = lim({9'h0, wv[F_VLIM +: 3]}, 12'h0, VLIM_MAX);
						lw = lim({8'h0, wv[F_WIN +: 4]}, WIN_MIN, WIN_MAX);
						nxt.sync = {lim(wv[F_FAIL +: 12], 12'h0, FAIL_MAX),
							la[3:0], lf[1:0], lv[2:0], lw[3:0]};
					end
					REG_DEBOUNCE:
					begin
						wv = merge({25'h0, q.deb}, dat_i, sel_i);
						ldb = lim({5'h0, wv[6:0]}, DEB_MIN, DEB_MAX);
						nxt.deb = ldb[6:0];
					end
					REG_SRC_CFG:  nxt.srcc = merge(q.srcc, dat_i, sel_i);
					REG_ROLE_DLY: nxt.rdly = merge(q.rdly, dat_i, sel_i);
					default:
					begin
						if (adr_i[7:6] != 2'h0 && adr_i[7:6] != 2'h3 &&
							adr_i[5:2] < 4'h9)
						begin
							wv = merge({8'h0, q.ld[idx[4:0]]}, dat_i, sel_i);
							nxt.ld[idx[4:0]] = wv[23:0];
						end
					end
				endcase
			end
		end

		// Sequencer; a fault raised here outranks a clear written above.
		case (q.st)
			ST_IDLE:
			begin
				nxt.busy = 1'b0;
				nxt.lo = '0;
				nxt.cmd = '0;
				// With the generator preferred, utility is used on its loss, or on a test or peak shave request while both are available.
				if (|q.avail && !(pos_i[want] && !pos_i[~want]))
				begin
					nxt.tgt = want;
					nxt.el = '0;
					nxt.busy = 1'b1;
					nxt.st = ST_PRE;
				end
			end
			ST_PRE:
			begin
				nxt.lo = pre_open;
				if (!(|q.avail) || want != q.tgt)
				begin
					nxt.lo = '0;
					nxt.st = ST_IDLE;
				end
				else if (q.el >= t_max)
				begin
					nxt.el = '0;
					nxt.st = ST_SYNC;
				end
				else if (q.sec)
					nxt.el = q.el + 16'h0001;
			end
			ST_SYNC:
			begin
				if (!q.avail[q.tgt])
				begin
					nxt.lo = '0;
					nxt.st = ST_IDLE;
				end
				else if (!hold)
					nxt.st = ST_XFER;
				else if (q.sec)
				begin
					if (q.el >= {4'h0, q.sync[F_FAIL +: 12]})
					begin
						nxt.fail = 1'b1;
						nxt.st = ST_XFER;
					end
					else
						nxt.el = q.el + 16'h0001;
				end
			end
			ST_XFER:
			begin
				nxt.cmd = q.tgt ? 2'b10 : 2'b01;
				nxt.lo = part;
				if (pos_i[q.tgt] && !pos_i[~q.tgt])
				begin
					nxt.cmd = '0;
					nxt.el = '0;
					nxt.st = ST_POST;
				end
			end
			ST_POST:
			begin
				nxt.lo = post_open;
				if (q.sec)
					nxt.el = q.el + 16'h0001;
				if (q.lo == '0)
					nxt.st = ST_IDLE;
			end
			default: nxt.st = ST_IDLE;
		endcase
	end

	// ===========================================================
	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
			q.ctrl <= CTRL_RST;
			q.sync <= SYNC_RST;
			q.deb <= DEB_RST;
			q.st <= ST_IDLE;
		end
		else
			q <= nxt;
	end

	assign dat_o       = q.rdat;
	assign ack_o       = q.ack;
	assign xfer_cmd_o  = q.cmd;
	assign load_open_o = q.lo;
	assign sync_fail_o = q.fail;
	assign seq_busy_o  = q.busy;

	// ===========================================================
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_pre_exit;
		q.st == ST_PRE ##1 q.st == ST_SYNC;
	endsequence

	a_ack_one_shot: assert property (q.ack |=> !q.ack)
		else $error("ack held longer than one cycle");
	a_bus_answer: assert property (cyc_i && stb_i && !q.ack |=> q.ack)
		else $error("bus request not answered next cycle");
	a_tick_chain: assert property (q.sec |-> $past(q.tenth))
		else $error("second tick without tenth tick");
	a_no_source_idle: assert property
		(q.st == ST_IDLE && q.avail == 2'b00 |=> q.st == ST_IDLE)
		else $error("sequence started with no source");
	a_pre_needs_both: assert property
		(q.st == ST_PRE && q.avail != 2'b11 |=> q.lo == '0)
		else $error("pre-transfer shed without both sources");
	a_pre_longest: assert property
		(s_pre_exit |-> $past(q.el) >= $past(t_max))
		else $error("transfer before longest delay");
	a_uu_immediate: assert property
		(q.st == ST_SYNC && q.avail[q.tgt] && model == MODEL_STD &&
		q.ctrl[F_IPM] && q.ctrl[F_MODE +: 2] == MODE_UU && rot_ok
		|=> q.st == ST_XFER)
		else $error("utility pair waited for phase");
	a_closed_hold: assert property
		(q.st == ST_SYNC && model == MODEL_CLOSED && both && !conn_low_i &&
		angle_diff_i > {4'h0, q.sync[F_ALIM +: 4]} && !q.sec
		|=> q.st == ST_SYNC)
		else $error("closed transfer outside angle limit");
	a_low_release: assert property
		(q.st == ST_SYNC && q.avail[q.tgt] && conn_low_i && rot_ok
		|=> q.st == ST_XFER)
		else $error("low connected source did not release");
	a_post_close: assert property
		(q.st == ST_POST && q.lo[0] && q.el >= rec_s[0] |=> !q.lo[0])
		else $error("load not reconnected after its delay");
	a_seek_pref: assert property
		(q.st == ST_IDLE && q.avail[pref] && !xfer_req_i &&
		pos_i[~pref] && !pos_i[pref]
		|=> q.st == ST_PRE && q.tgt == $past(pref))
		else $error("preferred source not sought");
endmodule

// *** test/tls_contactor_model.sv ***
// Behavioural contactor that follows the transfer command after a lag.
`timescale 1ns/1ns
module tls_contactor_model
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [1:0] xfer_cmd_i,
	input  wire logic [7:0] lag_i,
	output logic      [1:0] pos_o
);
	typedef struct packed
	{
		logic [1:0] pos;
		logic [7:0] cnt;
	} tls_cm_state_type;

	tls_cm_state_type state_ff;
	tls_cm_state_type nxt_state;

	// While it travels the contact shows neither source as closed.
	always_comb
	begin
		nxt_state = state_ff;
		if (xfer_cmd_i != 2'h0 && state_ff.pos != xfer_cmd_i)
		begin
			nxt_state.cnt = state_ff.cnt + 8'h01;
			nxt_state.pos = (state_ff.cnt >= lag_i) ? xfer_cmd_i : 2'h0;
		end
		else
		begin
			nxt_state.cnt = 8'h00;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_ff <= {2'h1, 8'h00};
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign pos_o = state_ff.pos;
endmodule

// *** test/test_transfer_load_sequencer.sv ***
// Self-checking testbench of the transfer load sequencer.
`timescale 1ns/1ns
module test_transfer_load_sequencer;
	import tls_pkg::*;

	logic       clk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
	logic [7:0] adr_i, angle_diff_i, volt_diff_i, freq_diff_i, lag;
	logic [31:0] dat_i, dat_o, q;
	logic [3:0] sel_i;
	logic [1:0] src_live_i, pos_i, rot_rev_i, xfer_cmd_o;
	logic       xfer_req_i, conn_low_i, approaching_i;
	logic       sync_fail_o, seq_busy_o;
	logic [NUM_LOADS-1:0] load_open_o;
	int         bad_count, cmp_count, n;

	tls_sequencer #(.TENTH_CYCLES(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
		.sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
		.src_live_i(src_live_i), .pos_i(pos_i), .xfer_req_i(xfer_req_i),
		.conn_low_i(conn_low_i), .rot_rev_i(rot_rev_i),
		.approaching_i(approaching_i), .angle_diff_i(angle_diff_i),
		.volt_diff_i(volt_diff_i), .freq_diff_i(freq_diff_i),
		.xfer_cmd_o(xfer_cmd_o), .load_open_o(load_open_o),
		.sync_fail_o(sync_fail_o), .seq_busy_o(seq_busy_o));

	tls_contactor_model u_contactor (.clk_i(clk_i), .rst_i(rst_i),
		.xfer_cmd_i(xfer_cmd_o), .lag_i(lag), .pos_o(pos_i));

	// ===========================================================
	// Shared tasks
	task automatic check(input string name, input logic [31:0] exp,
		input logic [31:0] seen);
		cmp_count++;
		if (exp !== seen)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic check_range(input string name, input int lo,
		input int hi, input int seen);
		cmp_count++;
		if (seen < lo || seen > hi)
		begin
			bad_count++;
			$display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi,
				seen);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && k < 100)
		begin
			k++;
			@(posedge clk_i);
		end
		check("bus ack", 32'h1, {31'h0, ack_o});
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	// Waits for busy (sel 0) or the transfer command (sel 1) to show v.
	task automatic wait_for(input logic sel, input logic [1:0] v,
		input int limit);
		n = 0;
		while (n < limit && (sel ? xfer_cmd_o !== v : seq_busy_o !== v[0]))
		begin
			@(negedge clk_i);
			n++;
		end
		check("wait", 32'h0, {31'h0, n >= limit});
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ===========================================================
	// Scenarios
	task automatic test_reset_values;
		wb(1'b0, REG_CTRL, 32'h0);
		check("ctrl reset", 32'h00004400, q);
		wb(1'b0, REG_SYNC, 32'h0);
		check("sync reset", 32'h0003D4D5, q);
		wb(1'b1, 8'hFC, 32'hFFFFFFFF);
		wb(1'b0, 8'hFC, 32'h0);
		check("unmapped", 32'h0, q);
	endtask

	task automatic test_no_source;
		xfer_req_i <= 1'b1;
		repeat (60) @(negedge clk_i);
		check("busy no src", 32'h0, {31'h0, seq_busy_o});
		check("loads no src", 32'h0, {23'h0, load_open_o});
	endtask

	task automatic test_shed_restore;
		xfer_req_i <= 1'b0;
		wb(1'b1, REG_CTRL, 32'h0000C402);
		wb(1'b1, REG_XFER_DLY, 32'h00000002);
		wb(1'b1, 8'h80, 32'h00001003);
		wb(1'b1, 8'h84, 32'h00003001);
		wb(1'b1, 8'h88, 32'h00000000);
		wb(1'b1, 8'h8C, 32'h00005005);
		wb(1'b1, 8'h40, 32'h0000000A);
		wb(1'b1, 8'h90, 32'h00000F00);
		wb(1'b0, 8'h90, 32'h0);
		check("load delay", 32'h00000F00, q);
		src_live_i <= 2'h3;
		repeat (5) @(posedge clk_i);
		xfer_req_i <= 1'b1;
		wait_for(1'b0, 2'h1, 50);
		repeat (50) @(negedge clk_i);
		check("pre loads", 32'h001, {23'h0, load_open_o});
		wait_for(1'b1, 2'h2, 400);
		check_range("xfer time", 190, 350, n + 50);
		check("shed", 32'h007, {23'h0, load_open_o});
		wait_for(1'b1, 2'h0, 50);
		repeat (150) @(negedge clk_i);
		check("post loads", 32'h002, {23'h0, load_open_o});
		wait_for(1'b0, 2'h0, 300);
		check("restored", 32'h0, {23'h0, load_open_o});
	endtask

	task automatic test_phase_hold;
		wb(1'b1, REG_CTRL, 32'h0000C482);
		wb(1'b1, REG_XFER_DLY, 32'h00010002);
		angle_diff_i <= 8'h14;
		lag <= 8'h14;
		xfer_req_i <= 1'b0;
		wait_for(1'b0, 2'h1, 50);
		repeat (400) @(negedge clk_i);
		check("held", 32'h0, {30'h0, xfer_cmd_o});
		check("no shed", 32'h0, {23'h0, load_open_o});
		angle_diff_i <= 8'h03;
		approaching_i <= 1'b1;
		wait_for(1'b1, 2'h1, 50);
		wait_for(1'b0, 2'h0, 200);
		approaching_i <= 1'b0;
		angle_diff_i <= 8'h14;
		conn_low_i <= 1'b1;
		xfer_req_i <= 1'b1;
		wait_for(1'b1, 2'h2, 450);
		wait_for(1'b0, 2'h0, 500);
		check("sync fault", 32'h0, {31'h0, sync_fail_o});
	endtask

	// Closed model with the angle outside its limit: the fail timer of
	// two seconds expires, raises the fault and lets the transfer go.
	task automatic test_sync_fail;
		conn_low_i <= 1'b0;
		wb(1'b1, REG_CTRL, 32'h00000410);
		wb(1'b1, REG_SYNC, 32'h000054D5);
		xfer_req_i <= 1'b0;
		wait_for(1'b0, 2'h1, 50);
		repeat (250) @(negedge clk_i);
		check("closed held", 32'h0, {30'h0, xfer_cmd_o});
		wait_for(1'b1, 2'h1, 600);
		check("fault set", 32'h1, {31'h0, sync_fail_o});
		wb(1'b0, REG_STATUS, 32'h0);
		check("fault status", 32'h1, {31'h0, q[0]});
		wb(1'b1, REG_STATUS, 32'h00000001);
		wb(1'b0, REG_STATUS, 32'h0);
		check("fault clear", 32'h0, {31'h0, q[0]});
		wait_for(1'b0, 2'h0, 500);
	endtask

	// ===========================================================
	// Clock, reset and sequence
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	initial
	begin
		rst_i = 1'b1;
		{we_i, cyc_i, stb_i, xfer_req_i, conn_low_i, approaching_i} = '0;
		{adr_i, angle_diff_i, volt_diff_i, freq_diff_i, lag} = '0;
		dat_i = '0;
		sel_i = 4'hF;
		src_live_i = 2'h0;
		rot_rev_i = 2'h0;
		bad_count = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		test_reset_values;
		test_no_source;
		test_shed_restore;
		test_phase_hold;
		test_sync_fail;
		complete_run;
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		$display("mismatch watchdog expected done seen timeout");
		complete_run;
	end
endmodule
